/* utxb_top.sv */
// Serial transceiver data path with AXI4-Lite register access.
//
// Contract
// - Buffer-empty flag high when transmit buffer empty, low while it holds data.
// - A data register write with byte lane 0 enabled clears the buffer-empty flag.
// - Buffer-empty request is a level while flag and enable are set.
// - Transmit-complete sets when frame shifted out and buffer empty.
// - Transmit-complete clears on interrupt service or software writing one.
// - Transmit-complete request raised as flag sets when enabled.
// - Parity inserted after last data bit when upper parity bit set.
// - Disabled transmitter finishes shifter and buffer before releasing pin.
// - Receive enable makes receiver own the serial input pin.
// - Synchronous mode samples bits on external serial clock.
// - Bits after valid start shifted in to first stop; second stop ignored.
// - On first stop bit frame moves into receive buffer.
// - Narrow characters read back with zeroed high bits.
// - Ninth bit and error flags stored per character; data read advances.
// - Reading data frees the buffer entry at once.
// - Buffer word moves to shifter when idle or after last stop.
// - Frame: low start, LSB first, optional parity, high stops; idle high.
// - Receive-complete reads one while unread data remain.
// - Receive buffer holds two characters first-in first-out.
`timescale 1ns/1ps
module utxb_top (
	// Clock and reset.
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// AXI4-Lite write channels.
	input  wire logic [3:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	// AXI4-Lite read channels.
	input  wire logic [3:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// Serial pins, interrupt acknowledge and interrupt requests.
	input  wire logic        serial_in_pin_i,
	input  wire logic        serial_clock_pin_i,
	output logic             serial_out_pin_o,
	output logic             serial_out_oe_o,
	output logic             rx_pin_owned_o,
	input  wire logic        tx_done_irq_ack_i,
	output logic             tx_empty_irq_o,
	output logic             tx_done_irq_o
);
	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic [7:0]  ctrl_b;
	logic [7:0]  fmt;
	logic [7:0]  tx_buf;
	logic        tx_buf_full;
	logic        tx_complete_flag;
	logic        aw_hold, w_hold;
	logic [3:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic [15:0] baud_cnt;
	logic        baud_tick, sclk_d, sclk_d2, sclk_d3, bit_tick;
	logic        rx_sync, rx_in;
	logic        frame_busy;
	logic [2:0]  char_size;
	logic [3:0]  nbits;
	logic        par_en, par_odd;
	utxb_pkg::utxb_tx_state_t tx_state;
	utxb_pkg::utxb_rx_state_t rx_state;
	logic [8:0]  tx_shift;
	logic [3:0]  tx_idx;
	logic        tx_par, tx_stop2, tx_stop_on;
	logic [8:0]  rx_shift;
	logic [3:0]  rx_idx;
	logic        rx_par, rx_par_err, rx_overrun;
	logic        wr_go, rd_data;

	utxb_rxq_if rxq ();
	utxb_rxq u_rxq (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .q(rxq.store));

	assign char_size = {ctrl_b[utxb_pkg::CB_RX_NINTH+1], fmt[utxb_pkg::FM_SIZE_LO+1 -: 2]};
	assign par_en    = fmt[utxb_pkg::FM_PAR_LO+1];
	assign par_odd   = fmt[utxb_pkg::FM_PAR_LO];
	// Nine-bit mode uses the spare control-b bit 2 as size high bit.
	assign nbits = (char_size == utxb_pkg::SIZE_NINE) ? 4'd9 :
	               4'(char_size[1:0]) + 4'd5;

	// ----------------------------------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------------------------------
	assign wr_go = aw_hold && w_hold && !s_axi_bvalid_o;

	// Address and data are latched in either order; response follows both.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_hold <= 1'b0; w_hold <= 1'b0; aw_addr <= '0; w_data <= '0; w_strb <= '0;
			s_axi_awready_o <= 1'b1; s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0; s_axi_bresp_o <= utxb_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_hold <= 1'b1; aw_addr <= s_axi_awaddr_i; s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_hold <= 1'b1; w_data <= s_axi_wdata_i; w_strb <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b0;
			end
			if (wr_go) begin
				aw_hold <= 1'b0; w_hold <= 1'b0; s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= (aw_addr[1:0] == 2'h0) ? utxb_pkg::RESP_OKAY
				                                       : utxb_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0; s_axi_awready_o <= 1'b1; s_axi_wready_o <= 1'b1;
			end
		end
	end

	// Control and format registers; lane 0 only carries data.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_b <= utxb_pkg::CTRL_B_RST;
			fmt    <= utxb_pkg::FORMAT_RST;
		end else begin
			if (wr_go && w_strb[0] && aw_addr == utxb_pkg::ADDR_CTRL_B)
				ctrl_b <= {w_data[7:2], ctrl_b[utxb_pkg::CB_RX_NINTH], w_data[0]};
			else
				ctrl_b[utxb_pkg::CB_RX_NINTH] <= rxq.rdata[8];
			if (wr_go && w_strb[0] && aw_addr == utxb_pkg::ADDR_FORMAT)
				fmt <= w_data[7:0];
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------------------------------
	assign rd_data = s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == utxb_pkg::ADDR_DATA;

	// Reads answer one cycle after the address is taken.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_arready_o <= 1'b1; s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= '0; s_axi_rresp_o <= utxb_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b1;
			s_axi_rresp_o   <= utxb_pkg::RESP_OKAY;
			if (s_axi_araddr_i == utxb_pkg::ADDR_DATA)
				s_axi_rdata_o <= {24'h0, rxq.rdata[7:0]};
			else if (s_axi_araddr_i == utxb_pkg::ADDR_STATUS)
				s_axi_rdata_o <= {24'h0, rxq.not_empty, tx_complete_flag,
				                  !tx_buf_full, rxq.rdata[11:9], 2'h0};
			else if (s_axi_araddr_i == utxb_pkg::ADDR_CTRL_B)
				s_axi_rdata_o <= {24'h0, ctrl_b};
			else if (s_axi_araddr_i == utxb_pkg::ADDR_FORMAT)
				s_axi_rdata_o <= {24'h0, fmt};
			else begin
				s_axi_rdata_o <= '0;
				s_axi_rresp_o <= utxb_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0; s_axi_arready_o <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Bit clock: internal divider or external serial clock edge
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			baud_cnt <= '0; baud_tick <= 1'b0; sclk_d <= 1'b0; sclk_d2 <= 1'b0;
			sclk_d3 <= 1'b0;
			rx_sync <= 1'b1; rx_in <= 1'b1;
		end else begin
			baud_tick <= (baud_cnt == utxb_pkg::BAUD_DIV);
			baud_cnt  <= (baud_cnt == utxb_pkg::BAUD_DIV) ? 16'h0 : baud_cnt + 16'h1;
			sclk_d  <= serial_clock_pin_i;
			sclk_d2 <= sclk_d;
			sclk_d3 <= sclk_d2;
			rx_sync <= serial_in_pin_i;
			rx_in   <= rx_sync;
		end
	end
	// Synchronous mode steps on the rising external clock edge.
	// The edge is taken behind the second flop so the first never feeds logic.
	assign bit_tick = fmt[utxb_pkg::FM_SYNC] ? (sclk_d2 & ~sclk_d3) : baud_tick;

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	// Buffer word, set by data writes, emptied when the shifter loads it.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_buf <= '0; tx_buf_full <= 1'b0;
		end else if (wr_go && w_strb[0] && aw_addr == utxb_pkg::ADDR_DATA) begin
			tx_buf <= w_data[7:0]; tx_buf_full <= 1'b1;
		end else if (bit_tick && tx_buf_full &&
		             (tx_state == utxb_pkg::UTXB_TX_IDLE ||
		              (tx_state == utxb_pkg::UTXB_TX_STOP && tx_stop_on && !tx_stop2))) begin
			tx_buf_full <= 1'b0;
		end
	end

	// Shifter state machine; line idles high.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_state <= utxb_pkg::UTXB_TX_IDLE; tx_shift <= '0; tx_idx <= '0;
			tx_par <= 1'b0; tx_stop2 <= 1'b0; serial_out_pin_o <= 1'b1;
			tx_stop_on <= 1'b0;
		end else if (bit_tick) begin
			case (tx_state)
				utxb_pkg::UTXB_TX_IDLE, utxb_pkg::UTXB_TX_STOP: begin
					if (tx_state == utxb_pkg::UTXB_TX_STOP && !tx_stop_on) begin
						// The first stop bit always goes out, even with a word waiting.
						tx_stop_on <= 1'b1; serial_out_pin_o <= 1'b1;
					end else if (tx_state == utxb_pkg::UTXB_TX_STOP && tx_stop2) begin
						tx_stop2 <= 1'b0; serial_out_pin_o <= 1'b1;
					end else if (tx_buf_full && (ctrl_b[utxb_pkg::CB_TX_EN] || frame_busy)) begin
						// Mask narrow characters, append the stored ninth bit.
						tx_shift <= {ctrl_b[utxb_pkg::CB_TX_NINTH], tx_buf} &
						            9'((10'h1 << nbits) - 10'h1);
						tx_par   <= par_odd;
						tx_idx   <= '0;
						tx_stop_on <= 1'b0;
						tx_state <= utxb_pkg::UTXB_TX_START;
						serial_out_pin_o <= 1'b0;
					end else begin
						tx_state <= utxb_pkg::UTXB_TX_IDLE; serial_out_pin_o <= 1'b1;
						tx_stop_on <= 1'b0;
					end
				end
				utxb_pkg::UTXB_TX_START, utxb_pkg::UTXB_TX_DATA: begin
					serial_out_pin_o <= tx_shift[0];
					tx_par   <= tx_par ^ tx_shift[0];
					tx_shift <= tx_shift >> 1;
					tx_idx   <= tx_idx + 4'h1;
					tx_state <= (tx_idx + 4'h1 == nbits) ?
					            (par_en ? utxb_pkg::UTXB_TX_PAR : utxb_pkg::UTXB_TX_STOP)
					            : utxb_pkg::UTXB_TX_DATA;
					if (tx_idx + 4'h1 == nbits && !par_en)
						tx_stop2 <= fmt[utxb_pkg::FM_STOP2];
				end
				utxb_pkg::UTXB_TX_PAR: begin
					serial_out_pin_o <= tx_par;
					tx_stop2 <= fmt[utxb_pkg::FM_STOP2];
					tx_state <= utxb_pkg::UTXB_TX_STOP;
				end
				default: tx_state <= utxb_pkg::UTXB_TX_IDLE;
			endcase
			if (tx_state == utxb_pkg::UTXB_TX_DATA && tx_idx == nbits)
				serial_out_pin_o <= 1'b1;
		end
	end

	// Pin ownership lasts while enabled or anything is pending.
	assign frame_busy = (tx_state != utxb_pkg::UTXB_TX_IDLE) || tx_buf_full;
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			serial_out_oe_o <= 1'b0;
		else
			serial_out_oe_o <= ctrl_b[utxb_pkg::CB_TX_EN] || frame_busy;
	end

	// Complete flag: set wins over any clear in the same cycle.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			tx_complete_flag <= 1'b0;
		else if (bit_tick && tx_state == utxb_pkg::UTXB_TX_STOP && tx_stop_on && !tx_stop2 &&
		         !tx_buf_full)
			tx_complete_flag <= 1'b1;
		else if (tx_done_irq_ack_i ||
		         (wr_go && w_strb[0] && aw_addr == utxb_pkg::ADDR_STATUS &&
		          w_data[utxb_pkg::ST_TX_DONE]))
			tx_complete_flag <= 1'b0;
	end

	// Interrupt request levels.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_empty_irq_o <= 1'b0; tx_done_irq_o <= 1'b0;
		end else begin
			tx_empty_irq_o <= !tx_buf_full && ctrl_b[utxb_pkg::CB_EMPTY_IE];
			tx_done_irq_o  <= tx_complete_flag && ctrl_b[utxb_pkg::CB_DONE_IE]
			                  && !tx_done_irq_ack_i;
		end
	end

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	assign rxq.pop   = rd_data;
	assign rxq.flush = !ctrl_b[utxb_pkg::CB_RX_EN];

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			rx_pin_owned_o <= 1'b0;
		else
			rx_pin_owned_o <= ctrl_b[utxb_pkg::CB_RX_EN];
	end

	// Receive shifter; stops at first stop bit and pushes to the buffer.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_state <= utxb_pkg::UTXB_RX_IDLE; rx_shift <= '0; rx_idx <= '0;
			rx_par <= 1'b0; rx_par_err <= 1'b0; rx_overrun <= 1'b0;
			rxq.push <= 1'b0; rxq.wdata <= '0;
		end else begin
			rxq.push <= 1'b0;
			if (!ctrl_b[utxb_pkg::CB_RX_EN]) begin
				rx_state <= utxb_pkg::UTXB_RX_IDLE;
			end else if (bit_tick) begin
				case (rx_state)
					utxb_pkg::UTXB_RX_IDLE: if (!rx_in) begin
						rx_overrun <= rxq.full;
						rx_idx <= '0; rx_shift <= '0; rx_par <= par_odd;
						rx_state <= utxb_pkg::UTXB_RX_DATA;
					end
					utxb_pkg::UTXB_RX_DATA: begin
						// Each bit enters at the top of the character and moves down.
						if (rx_idx == 4'h0) rx_shift <= 9'(rx_in) << 4'(nbits - 4'h1);
						else rx_shift <= (rx_shift >> 1) | (9'(rx_in) << 4'(nbits - 4'h1));
						rx_par <= rx_par ^ rx_in;
						rx_idx <= rx_idx + 4'h1;
						if (rx_idx + 4'h1 == nbits)
							rx_state <= par_en ? utxb_pkg::UTXB_RX_PAR : utxb_pkg::UTXB_RX_STOP;
					end
					utxb_pkg::UTXB_RX_PAR: begin
						rx_par_err <= rx_par ^ rx_in;
						rx_state   <= utxb_pkg::UTXB_RX_STOP;
					end
					utxb_pkg::UTXB_RX_STOP: begin
						rxq.push  <= !rxq.full;
						rxq.wdata <= {!rx_in, rx_overrun, par_en & rx_par_err, rx_shift};
						rx_par_err <= 1'b0;
						rx_state  <= utxb_pkg::UTXB_RX_IDLE;
					end
					default: rx_state <= utxb_pkg::UTXB_RX_IDLE;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_write_clears_empty: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		wr_go && w_strb[0] && aw_addr == utxb_pkg::ADDR_DATA |=> tx_buf_full)
		else $error("data write did not fill transmit buffer");
	a_empty_irq_level: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		!tx_buf_full && ctrl_b[utxb_pkg::CB_EMPTY_IE] |=> tx_empty_irq_o)
		else $error("empty request missing");
	a_done_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$rose(tx_complete_flag) |-> $past(tx_state) == utxb_pkg::UTXB_TX_STOP && !tx_buf_full)
		else $error("complete flag rose outside stop bit");
	a_done_irq: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$rose(tx_complete_flag) && ctrl_b[utxb_pkg::CB_DONE_IE] && !tx_done_irq_ack_i
		|=> tx_done_irq_o)
		else $error("complete request missing");
	a_oe_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		frame_busy |=> serial_out_oe_o)
		else $error("pin released during frame");
	a_rx_own: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		ctrl_b[utxb_pkg::CB_RX_EN] |=> rx_pin_owned_o)
		else $error("receiver did not take pin");
	a_flag_empty: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		rxq.push && ctrl_b[utxb_pkg::CB_RX_EN] |=> rxq.not_empty)
		else $error("receive flag low after push");
	a_start_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
		$past(tx_state) == utxb_pkg::UTXB_TX_IDLE && tx_state == utxb_pkg::UTXB_TX_START
		|-> !serial_out_pin_o)
		else $error("start bit not low");
endmodule : utxb_top

/* utxb_pkg.sv */
// Package of constants for the serial transceiver data path.
package utxb_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses on AXI4-Lite)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_DATA   = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_CTRL_B = 4'h8;
	localparam logic [3:0] ADDR_FORMAT = 4'hc;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int ST_PARITY_ERR = 2;
	localparam int ST_OVERRUN    = 3;
	localparam int ST_FRAME_ERR  = 4;
	localparam int ST_BUF_EMPTY  = 5;
	localparam int ST_TX_DONE    = 6;
	localparam int ST_RX_DONE    = 7;
	localparam int CB_TX_NINTH   = 0;
	localparam int CB_RX_NINTH   = 1;
	localparam int CB_TX_EN      = 3;
	localparam int CB_RX_EN      = 4;
	localparam int CB_EMPTY_IE   = 5;
	localparam int CB_DONE_IE    = 6;
	localparam int FM_SIZE_LO    = 1;
	localparam int FM_STOP2      = 3;
	localparam int FM_PAR_LO     = 4;
	localparam int FM_SYNC       = 6;

	// ----------------------------------------------------------------
	// Reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [7:0]  CTRL_B_RST  = 8'h00;
	localparam logic [7:0]  FORMAT_RST  = 8'h06;
	localparam logic [2:0]  SIZE_NINE   = 3'h7;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [15:0] BAUD_DIV    = 16'h006c;
	localparam int          RXQ_DEPTH   = 2;
	localparam int          RXQ_WIDTH   = 12;

	typedef enum logic [2:0] {
		UTXB_TX_IDLE, UTXB_TX_START, UTXB_TX_DATA, UTXB_TX_PAR, UTXB_TX_STOP
	} utxb_tx_state_t;

	typedef enum logic [2:0] {
		UTXB_RX_IDLE, UTXB_RX_DATA, UTXB_RX_PAR, UTXB_RX_STOP
	} utxb_rx_state_t;

endpackage : utxb_pkg

/* utxb_rxq_if.sv */
// Interface between the receiver and its two-entry receive buffer.
`timescale 1ns/1ps
interface utxb_rxq_if;
	logic                          push;
	logic [utxb_pkg::RXQ_WIDTH-1:0] wdata;
	logic                          pop;
	logic                          flush;
	logic [utxb_pkg::RXQ_WIDTH-1:0] rdata;
	logic                          not_empty;
	logic                          full;
	modport owner (output push, wdata, pop, flush, input rdata, not_empty, full);
	modport store (input push, wdata, pop, flush, output rdata, not_empty, full);
endinterface : utxb_rxq_if

/* utxb_rxq.sv */
// Two-entry receive buffer holding data, ninth bit and error flags.
`timescale 1ns/1ps
module utxb_rxq (
	// Clock and reset.
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	// Buffer port.
	utxb_rxq_if.store q
);
	logic [utxb_pkg::RXQ_WIDTH-1:0] mem [utxb_pkg::RXQ_DEPTH];
	logic [1:0]                     count;
	logic                           wr_ptr;
	logic                           rd_ptr;

	// Occupancy and pointers; flush empties at once.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			count  <= 2'h0;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
		end else if (q.flush) begin
			count  <= 2'h0;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
		end else begin
			if (q.push && !q.full)
				wr_ptr <= ~wr_ptr;
			if (q.pop && q.not_empty)
				rd_ptr <= ~rd_ptr;
			count <= count + 2'((q.push && !q.full) ? 1 : 0) - 2'((q.pop && q.not_empty) ? 1 : 0);
		end
	end

	// Storage cells, one per entry.
	for (genvar i = 0; i < utxb_pkg::RXQ_DEPTH; i++) begin : g_cell
		always_ff @(posedge ref_clk_i) begin
			if (q.push && !q.full && !q.flush && wr_ptr == 1'(i))
				mem[i] <= q.wdata;
		end
	end

	// Registered head of the queue; shows the next entry one cycle after a pop moves the read pointer.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			q.rdata <= '0;
		else
			q.rdata <= mem[rd_ptr];
	end

	assign q.not_empty = (count != 2'h0);
	assign q.full      = (count == 2'(utxb_pkg::RXQ_DEPTH));
endmodule : utxb_rxq

/* utxb_remote.sv */
// Remote serial node model that drives the receive line and captures sent frames.
`timescale 1ns/1ps
module utxb_remote #(
	parameter int BIT_CLKS = 109
) (
	// Clock.
	input  wire logic        ref_clk_i,
	// Line side.
	input  wire logic        line_i,
	output logic             line_o,
	output logic [10:0]      cap_o,
	output logic             sclk_o
);
	// The line idles high between frames; the serial clock idles low.
	initial line_o = 1'b1;
	initial sclk_o = 1'b0;

	// Sends eleven bit times, bit 0 first; callers pad with idle ones.
	task automatic send(input logic [10:0] f);
		for (int i = 0; i < 11; i++) begin
			line_o <= f[i];
			repeat (BIT_CLKS) @(posedge ref_clk_i);
		end
		// Extra idle lets the receiver finish its last sample before any read.
		repeat (4) @(posedge ref_clk_i);
	endtask : send

	// Sends eleven bits with a rising serial clock in the middle of each bit.
	task automatic send_sync(input logic [10:0] f);
		for (int i = 0; i < 11; i++) begin
			line_o <= f[i];
			repeat (4) @(posedge ref_clk_i);
			sclk_o <= 1'b1;
			repeat (4) @(posedge ref_clk_i);
			sclk_o <= 1'b0;
		end
		repeat (8) @(posedge ref_clk_i);
	endtask : send_sync

	// Samples mid-bit after each falling edge; back-to-back frames confuse it, so
	// callers only trust the capture of a lone frame.
	initial forever begin
		@(negedge line_i);
		repeat (BIT_CLKS / 2) @(posedge ref_clk_i);
		for (int i = 0; i < 11; i++) begin
			cap_o[i] <= line_i;
			repeat (BIT_CLKS) @(posedge ref_clk_i);
		end
	end
endmodule : utxb_remote

/* tb_utxb_top.sv */
// Self-checking testbench for the serial transceiver data path.
`timescale 1ns/1ps
module tb_utxb_top;
	typedef struct packed {logic [7:0] fmt, cb, d; logic [10:0] ln; logic [7:0] rx;} utxb_row_t;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam logic [3:0] A_DT = utxb_pkg::ADDR_DATA;
	localparam logic [3:0] A_ST = utxb_pkg::ADDR_STATUS;
	localparam logic [3:0] A_CB = utxb_pkg::ADDR_CTRL_B;
	logic        ref_clk_i = 1'b0;
	logic        rst_i     = 1'b1;
	logic [3:0]  awaddr    = 4'h0;
	logic [3:0]  araddr    = 4'h0;
	logic [31:0] wdata     = 32'h0;
	logic        awvalid   = 1'b0;
	logic        wvalid    = 1'b0;
	logic        bready    = 1'b0;
	logic        arvalid   = 1'b0;
	logic        rready    = 1'b0;
	logic        ack       = 1'b0;
	logic        sclk;
	logic        awready, wready, bvalid, arready, rvalid, tx_pin, oe, owned, eirq, dirq, rx_line;
	logic [1:0]  bresp, rresp, rr;
	logic [31:0] rdata, rv;
	logic [10:0] cap;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          cyc       = 0;
	// Format, control, written word, expected line bits, expected received word.
	utxb_row_t   rows [5]  = '{
		'{8'h06, 8'h00, 8'ha5, 11'h74a, 8'ha5}, '{8'h26, 8'h00, 8'h07, 11'h60e, 8'h07},
		'{8'h36, 8'h00, 8'h07, 11'h40e, 8'h07}, '{8'h00, 8'h00, 8'h4a, 11'h7d4, 8'h0a},
		'{8'h06, 8'h05, 8'h3c, 11'h678, 8'h3c}};

	// Clock at 200 MHz.
	always #2.5 ref_clk_i = ~ref_clk_i;

	utxb_top u_dut (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
		.s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
		.s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.serial_in_pin_i(rx_line), .serial_clock_pin_i(sclk), .serial_out_pin_o(tx_pin),
		.serial_out_oe_o(oe), .rx_pin_owned_o(owned), .tx_done_irq_ack_i(ack),
		.tx_empty_irq_o(eirq), .tx_done_irq_o(dirq));

	utxb_remote #(.BIT_CLKS(int'(utxb_pkg::BAUD_DIV) + 1)) u_rem (
		.ref_clk_i(ref_clk_i), .line_i(tx_pin), .line_o(rx_line), .cap_o(cap), .sclk_o(sclk));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// Address and data go out together; each drops when taken.
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		awaddr  <= a;
		wdata   <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk_i);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rv = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask : rd

	// Status reads have no side effects, so polling is safe.
	task automatic wait_flag(input int b);
		do rd(A_ST); while (rv[b] !== 1'b1);
	endtask : wait_flag

	task automatic conclude();
		$display("compares %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : conclude

	// Hang guard, well above the roughly 18500 cycles the tests need.
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt++;
			conclude();
		end
	end

	// Table rows first, then the hand-written cases.
	initial begin
		repeat (12) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		foreach (rows[i]) begin
			wr(utxb_pkg::ADDR_FORMAT, rows[i].fmt);
			wr(A_CB, rows[i].cb | 8'h18);
			wr(A_DT, rows[i].d);
			wait_flag(utxb_pkg::ST_TX_DONE);
			repeat (300) @(posedge ref_clk_i);
			chk("tx frame", {21'h0, rows[i].ln}, {21'h0, cap});
			wr(A_ST, 8'h40);
			u_rem.send(rows[i].ln);
			rd(A_ST);
			chk("status", 32'ha0, rv);
			rd(A_CB);
			if (rows[i].cb[2]) chk("rx ninth", 32'h1, 32'(rv[1]));
			rd(A_DT);
			chk("rx data", {24'h0, rows[i].rx}, rv);
			rd(A_ST);
			chk("rx drained", 32'h0, 32'(rv[7]));
			$display("row %0d done", i);
		end
		wr(A_CB, 8'h68);
		repeat (2) @(posedge ref_clk_i);
		chk("empty irq", 32'h1, 32'(eirq));
		wr(A_DT, 8'h11);
		wait_flag(utxb_pkg::ST_BUF_EMPTY);
		wr(A_DT, 8'h22);
		rd(A_ST);
		chk("buffer empty", 32'h0, 32'(rv[5]));
		chk("empty irq", 32'h0, 32'(eirq));
		wr(A_CB, 8'h60);
		repeat (1100) @(posedge ref_clk_i);
		chk("pin kept", 32'h1, 32'(oe));
		rd(A_ST);
		chk("early done", 32'h0, 32'(rv[6]));
		wait_flag(utxb_pkg::ST_TX_DONE);
		repeat (4) @(posedge ref_clk_i);
		chk("done irq", 32'h1, 32'(dirq));
		chk("pin released", 32'h0, 32'(oe));
		ack <= 1'b1;
		@(posedge ref_clk_i);
		ack <= 1'b0;
		rd(A_ST);
		chk("done cleared", 32'h0, 32'(rv[6]));
		$display("transmit flags test done");
		wr(A_CB, 8'h10);
		u_rem.send(11'h74a);
		u_rem.send(11'h60e);
		chk("rx pin owned", 32'h1, 32'(owned));
		rd(A_DT);
		chk("fifo first", 32'ha5, rv);
		rd(A_DT);
		chk("fifo second", 32'h07, rv);
		rd(A_ST);
		chk("fifo empty", 32'h0, 32'(rv[7]));
		rd(4'h2);
		chk("bad address", 32'(utxb_pkg::RESP_SLVERR), 32'(rr));
		$display("receive buffer test done");
		rst_i <= 1'b1;
		repeat (12) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rd(utxb_pkg::ADDR_FORMAT);
		chk("format reset", 32'(utxb_pkg::FORMAT_RST), rv);
		rd(A_CB);
		chk("control reset", 32'(utxb_pkg::CTRL_B_RST), rv);
		rd(A_ST);
		chk("status reset", 32'h20, rv);
		$display("reset test done");
		wr(utxb_pkg::ADDR_FORMAT, 8'h46);
		wr(A_CB, 8'h10);
		u_rem.send_sync(11'h74a);
		rd(A_DT);
		chk("sync rx data", 32'ha5, rv);
		$display("synchronous test done");
		conclude();
	end
endmodule : tb_utxb_top
